// ---- src/psc_device.sv ----
// Device end: passive serial loader with reset, configuration and initialization stages
module psc_device #(
    parameter bit OSC_INIT = 1'b1,
    parameter int INIT_CYCLES = psc_pkg::INIT_CYC_LONG,
    parameter int CFG_BYTES = 16,
    parameter int POR_CYCLES = psc_pkg::POR_CYC,
    parameter int RESTART_CYCLES = psc_pkg::RESTART_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    psc_if.dev link,
    output logic [7:0] cfg_byte,
    output logic cfg_byte_valid,
    output logic cfg_error,
    output logic user_mode,
    output logic io_tristate,
    output logic io_pullup_en
);
    typedef struct packed {
        psc_pkg::psc_dev_state_t st;
        logic [15:0] cnt;
        logic [4:0] osc_div;
        logic cclk_q;
        logic uclk_q;
        logic [2:0] bit_idx;
        logic [7:0] shreg;
        logic [15:0] byte_idx;
        logic ie_en;
        logic auto_rst;
        logic usr_clk;
        logic status_oe;
        logic done_oe;
        logic init_oe;
        logic [7:0] byte_o;
        logic byte_v;
        logic err;
        logic umode;
        logic io_tri;
        logic pull_en;
    } psc_dev_reg_t;

    localparam psc_dev_reg_t RESET_VAL = '{
        st: psc_pkg::DEV_POR,
        status_oe: 1'b1,
        done_oe: 1'b1,
        io_tri: 1'b1,
        pull_en: 1'b1,
        default: '0
    };

    psc_dev_reg_t r;
    psc_dev_reg_t r_nxt;
    logic s_req;
    logic s_status;
    logic s_cclk;
    logic s_data;
    logic s_uclk;

    // Every link input crosses into the core domain here
    psc_sync #(.W(5)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .d({link.config_request_n, link.status_n, link.config_clock, link.serial_data_in, link.user_init_clock}),
        .q({s_req, s_status, s_cclk, s_data, s_uclk})
    );

    always_comb begin
        logic cclk_rise;
        logic uclk_rise;
        logic osc_tick;
        logic init_tick;
        logic [7:0] nb;
        cclk_rise = s_cclk & ~r.cclk_q;
        uclk_rise = s_uclk & ~r.uclk_q;
        osc_tick = (r.osc_div == 5'(psc_pkg::OSC_DIV - 1));
        init_tick = 1'b0;
        nb = {s_data, r.shreg[7:1]};
        r_nxt = r;
        r_nxt.cclk_q = s_cclk;
        r_nxt.uclk_q = s_uclk;
        r_nxt.byte_v = 1'b0;
        r_nxt.err = 1'b0;
        r_nxt.osc_div = osc_tick ? 5'h0 : r.osc_div + 5'h1;
        // Choice of initialization clock by variant and option
        if (r.usr_clk) begin
            init_tick = uclk_rise;
        end else if (OSC_INIT) begin
            init_tick = osc_tick;
        end else begin
            init_tick = cclk_rise;
        end
        case (r.st)
            psc_pkg::DEV_POR: begin
                r_nxt.cnt = r.cnt + 16'h1;
                if (r.cnt == 16'(POR_CYCLES - 1)) begin
                    r_nxt.st = psc_pkg::DEV_RESET;
                    r_nxt.cnt = '0;
                end
            end
            psc_pkg::DEV_RESET: begin
                r_nxt.status_oe = ~s_req;
                r_nxt.done_oe = 1'b1;
                r_nxt.bit_idx = '0;
                r_nxt.byte_idx = '0;
                r_nxt.cnt = '0;
                // Status must be seen high on the line, another party may still hold it
                if (s_req && s_status && !r.status_oe) begin
                    r_nxt.st = psc_pkg::DEV_CONFIG;
                end
            end
            psc_pkg::DEV_CONFIG: begin
                // A stopped config_clock simply leaves this state waiting
                if (!s_status) begin
                    r_nxt.st = psc_pkg::DEV_RESET;
                end else if (cclk_rise) begin
                    r_nxt.shreg = nb;
                    r_nxt.bit_idx = r.bit_idx + 3'h1;
                    if (r.bit_idx == 3'h7) begin
                        r_nxt.byte_o = nb;
                        r_nxt.byte_v = 1'b1;
                        r_nxt.byte_idx = r.byte_idx + 16'h1;
                        if (r.byte_idx == 16'h0 && nb != psc_pkg::SYNC_BYTE) begin
                            r_nxt.st = psc_pkg::DEV_ERROR;
                            r_nxt.status_oe = 1'b1;
                            r_nxt.err = 1'b1;
                        end else begin
                            if (r.byte_idx == 16'(psc_pkg::OPT_BYTE_IDX)) begin
                                r_nxt.ie_en = nb[psc_pkg::OPT_INIT_DONE_BIT];
                                r_nxt.auto_rst = nb[psc_pkg::OPT_AUTO_RESTART_BIT];
                                r_nxt.usr_clk = nb[psc_pkg::OPT_USER_CLK_BIT];
                                r_nxt.init_oe = nb[psc_pkg::OPT_INIT_DONE_BIT];
                            end
                            if (r.byte_idx == 16'(CFG_BYTES - 1)) begin
                                r_nxt.st = psc_pkg::DEV_INIT;
                                r_nxt.done_oe = 1'b0;
                            end
                        end
                    end
                end
            end
            psc_pkg::DEV_INIT: begin
                if (!s_status) begin
                    r_nxt.st = psc_pkg::DEV_RESET;
                end else if (init_tick) begin
                    r_nxt.cnt = r.cnt + 16'h1;
                    if (r.cnt == 16'(INIT_CYCLES - 1)) begin
                        r_nxt.st = psc_pkg::DEV_USER;
                        r_nxt.init_oe = 1'b0;
                        r_nxt.umode = 1'b1;
                        r_nxt.io_tri = 1'b0;
                        r_nxt.pull_en = 1'b0;
                    end
                end
            end
            psc_pkg::DEV_USER: begin
                // Further clock edges are ignored here
                r_nxt.cnt = r.cnt;
            end
            psc_pkg::DEV_ERROR: begin
                r_nxt.status_oe = 1'b1;
                r_nxt.init_oe = 1'b0;
                if (r.auto_rst) begin
                    r_nxt.cnt = r.cnt + 16'h1;
                    if (r.cnt == 16'(RESTART_CYCLES - 1)) begin
                        r_nxt.st = psc_pkg::DEV_RESET;
                        r_nxt.cnt = '0;
                    end
                end
            end
            default: begin
                r_nxt.st = psc_pkg::DEV_RESET;
            end
        endcase
        // Request low overrides every stage but power-on reset
        if (!s_req && r.st != psc_pkg::DEV_POR) begin
            r_nxt.st = psc_pkg::DEV_RESET;
            r_nxt.status_oe = 1'b1;
            r_nxt.done_oe = 1'b1;
            r_nxt.init_oe = 1'b0;
            r_nxt.ie_en = 1'b0;
            // Auto restart outlives a request pulse, else a sync-byte error could never restart
            r_nxt.usr_clk = 1'b0;
            r_nxt.umode = 1'b0;
            r_nxt.io_tri = 1'b1;
            r_nxt.pull_en = 1'b1;
        end
        // Any way into reset or error tri-states the user I/O again
        if (r_nxt.st == psc_pkg::DEV_ERROR || r_nxt.st == psc_pkg::DEV_RESET) begin
            r_nxt.umode = 1'b0;
            r_nxt.io_tri = 1'b1;
            r_nxt.pull_en = 1'b1;
            r_nxt.done_oe = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            r <= RESET_VAL;
        end else begin
            r <= r_nxt;
        end
    end

    assign link.status_n_o = 1'b0;
    assign link.status_n_oe = r.status_oe;
    assign link.config_complete_o = 1'b0;
    assign link.config_complete_oe = r.done_oe;
    assign link.init_complete_o = 1'b0;
    assign link.init_complete_oe = r.init_oe;
    assign cfg_byte = r.byte_o;
    assign cfg_byte_valid = r.byte_v;
    assign cfg_error = r.err;
    assign user_mode = r.umode;
    assign io_tristate = r.io_tri;
    assign io_pullup_en = r.pull_en;
endmodule

// ---- src/psc_pkg.sv ----
// Shared constants and types for the passive serial configuration port
package psc_pkg;
    // Core clock rate
    localparam int CLK_MHZ = 250;
    // Power-on reset time, about 5 us
    localparam int POR_NS = 5000;
    localparam int POR_CYC = POR_NS * CLK_MHZ / 1000;
    // Automatic restart time-out, at most 40 us, so rounded down
    localparam int RESTART_NS = 40000;
    localparam int RESTART_CYC = RESTART_NS * CLK_MHZ / 1000;
    // Internal initialization oscillator, typically 10 MHz
    localparam int OSC_KHZ = 10000;
    localparam int OSC_DIV = CLK_MHZ * 1000 / OSC_KHZ;
    // Least low time of config_request_n for reconfiguration, 21, 8 or 2 us
    localparam int RECONF_NS = 21000;
    localparam int RECONF_CYC = (RECONF_NS * CLK_MHZ + 999) / 1000;
    // Longest wait from config_complete to user mode seen by the host
    localparam int INIT_TIMEOUT_NS = 28000;
    localparam int INIT_TIMEOUT_CYC = INIT_TIMEOUT_NS * CLK_MHZ / 1000;
    // Initialization clock cycles per variant
    localparam int INIT_CYC_LONG = 136;
    localparam int INIT_CYC_MID = 40;
    localparam int INIT_CYC_SHORT = 10;
    // Half periods of the clocks that the host makes, in core cycles
    localparam int CCLK_HALF = 10;
    localparam int UCLK_HALF = 12;
    // Stream layout: byte 0 is a sync word that must equal SYNC_BYTE, byte 1 holds options
    localparam logic [7:0] SYNC_BYTE = 8'h5a;
    localparam int OPT_BYTE_IDX = 1;
    localparam int OPT_INIT_DONE_BIT = 0;
    localparam int OPT_AUTO_RESTART_BIT = 1;
    localparam int OPT_USER_CLK_BIT = 2;
    // Host register map, byte addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h8;
    // CTRL fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_AUTO_RETRY_BIT = 1;
    localparam int CTRL_USE_INIT_DONE_BIT = 2;
    localparam int CTRL_UCLK_EN_BIT = 3;
    localparam int CTRL_CONFIG_CLOCK_INIT_BIT = 4;
    // STAT fields
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    localparam int STAT_STATUS_PIN_BIT = 2;
    localparam int STAT_CDONE_PIN_BIT = 3;
    localparam int STAT_IDONE_PIN_BIT = 4;
    localparam int STAT_DATA_READY_BIT = 5;
    localparam int STAT_BUSY_BIT = 6;

    typedef enum logic [2:0] {DEV_POR, DEV_RESET, DEV_CONFIG, DEV_INIT, DEV_USER, DEV_ERROR} psc_dev_state_t;
    typedef enum logic [2:0] {H_IDLE, H_PULSE, H_WAIT, H_SEND, H_INIT, H_DONE, H_ERR} psc_host_state_t;
endpackage

// ---- src/psc_if.sv ----
// Configuration link between host and device, with open-drain pull-ups
interface psc_if;
    logic config_request_n;
    logic config_clock;
    logic serial_data_in;
    logic user_init_clock;
    logic status_n_o;
    logic status_n_oe;
    logic config_complete_o;
    logic config_complete_oe;
    logic init_complete_o;
    logic init_complete_oe;
    logic status_n;
    logic config_complete;
    logic init_complete;

    // Open-drain lines read high unless the device pulls them
    assign status_n = status_n_oe ? status_n_o : 1'b1;
    assign config_complete = config_complete_oe ? config_complete_o : 1'b1;
    assign init_complete = init_complete_oe ? init_complete_o : 1'b1;

    modport dev (
        input config_request_n, config_clock, serial_data_in, user_init_clock, status_n,
        output status_n_o, status_n_oe, config_complete_o, config_complete_oe, init_complete_o, init_complete_oe
    );
    modport host (
        output config_request_n, config_clock, serial_data_in, user_init_clock,
        input status_n, config_complete, init_complete
    );
endinterface

// ---- src/psc_sync.sv ----
// Two-flop synchroniser for pins from outside the core clock domain
module psc_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } psc_sync_reg_t;

    psc_sync_reg_t r;
    psc_sync_reg_t r_nxt;

    always_comb begin
        r_nxt.s1 = d;
        r_nxt.s2 = r.s1;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign q = r.s2;
endmodule

// ---- src/psc_host.sv ----
// Host end: drives the configuration link under Avalon-MM register control
module psc_host #(
    parameter int RECONF_CYCLES = psc_pkg::RECONF_CYC,
    parameter int INIT_TIMEOUT = psc_pkg::INIT_TIMEOUT_CYC,
    parameter int CCLK_HALF = psc_pkg::CCLK_HALF,
    parameter int UCLK_HALF = psc_pkg::UCLK_HALF
) (
    input wire logic core_clk,
    input wire logic rst,
    psc_if.host link,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    typedef struct packed {
        psc_pkg::psc_host_state_t st;
        logic [15:0] cnt;
        logic [7:0] phase;
        logic [7:0] ucnt;
        logic req_n;
        logic cclk;
        logic sdata;
        logic uclk;
        logic [7:0] shreg;
        logic [3:0] bits;
        logic auto_retry;
        logic use_id;
        logic uclk_en;
        logic config_clock_init;
        logic done;
        logic err;
        logic wait_r;
        logic [31:0] rdata;
    } psc_host_reg_t;

    psc_host_reg_t r;
    psc_host_reg_t r_nxt;
    logic s_status;
    logic s_cdone;
    logic s_idone;

    psc_sync #(.W(3)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .d({link.status_n, link.config_complete, link.init_complete}),
        .q({s_status, s_cdone, s_idone})
    );

    always_comb begin
        logic data_ok;
        logic half;
        logic req;
        data_ok = (r.st != psc_pkg::H_SEND) || (r.bits == 4'h0);
        half = (r.phase == 8'(CCLK_HALF - 1));
        req = r.wait_r && (avs_read || avs_write);
        r_nxt = r;
        r_nxt.wait_r = 1'b1;
        // User clock runs free while enabled, status low included
        if (r.uclk_en) begin
            r_nxt.ucnt = (r.ucnt == 8'(UCLK_HALF - 1)) ? 8'h0 : r.ucnt + 8'h1;
            r_nxt.uclk = (r.ucnt == 8'(UCLK_HALF - 1)) ? ~r.uclk : r.uclk;
        end else begin
            r_nxt.ucnt = '0;
            r_nxt.uclk = 1'b0;
        end
        case (r.st)
            psc_pkg::H_PULSE: begin
                r_nxt.cnt = r.cnt + 16'h1;
                if (r.cnt == 16'(RECONF_CYCLES - 1)) begin
                    r_nxt.req_n = 1'b1;
                    r_nxt.st = psc_pkg::H_WAIT;
                end
            end
            psc_pkg::H_WAIT: begin
                if (s_status) begin
                    r_nxt.st = psc_pkg::H_SEND;
                    r_nxt.bits = '0;
                end
            end
            psc_pkg::H_SEND: begin
                if (!s_status) begin
                    r_nxt.st = psc_pkg::H_ERR;
                    r_nxt.err = 1'b1;
                    r_nxt.cclk = 1'b0;
                    r_nxt.bits = '0;
                end else if (s_cdone) begin
                    r_nxt.st = psc_pkg::H_INIT;
                    r_nxt.cclk = 1'b0;
                    r_nxt.sdata = 1'b0;
                    r_nxt.bits = '0;
                    r_nxt.cnt = '0;
                    r_nxt.phase = '0;
                end else if (r.bits != 4'h0) begin
                    r_nxt.phase = half ? 8'h0 : r.phase + 8'h1;
                    if (half) begin
                        r_nxt.cclk = ~r.cclk;
                        // Data moves on the falling edge, so it is stable across the rise
                        if (r.cclk) begin
                            r_nxt.shreg = {1'b0, r.shreg[7:1]};
                            r_nxt.sdata = r.shreg[1];
                            r_nxt.bits = r.bits - 4'h1;
                        end
                    end
                end
            end
            psc_pkg::H_INIT: begin
                r_nxt.cnt = r.cnt + 16'h1;
                if (r.config_clock_init) begin
                    r_nxt.phase = half ? 8'h0 : r.phase + 8'h1;
                    r_nxt.cclk = half ? ~r.cclk : r.cclk;
                end
                if (r.use_id && s_idone) begin
                    r_nxt.st = psc_pkg::H_DONE;
                    r_nxt.done = 1'b1;
                end else if (!s_status || !s_cdone) begin
                    r_nxt.st = psc_pkg::H_ERR;
                    r_nxt.err = 1'b1;
                end else if (r.cnt == 16'(INIT_TIMEOUT - 1)) begin
                    r_nxt.st = r.use_id ? psc_pkg::H_ERR : psc_pkg::H_DONE;
                    r_nxt.err = r.use_id;
                    r_nxt.done = ~r.use_id;
                end
            end
            psc_pkg::H_DONE, psc_pkg::H_ERR, psc_pkg::H_IDLE: begin
                r_nxt.cclk = 1'b0;
                r_nxt.sdata = 1'b0;
            end
            default: begin
                r_nxt.st = psc_pkg::H_IDLE;
            end
        endcase
        // Slave side: one wait cycle, DATA writes stall until the shifter is empty
        if (req && !(avs_write && avs_address == psc_pkg::REG_DATA && !data_ok)) begin
            r_nxt.wait_r = 1'b0;
            r_nxt.rdata = '0;
            if (avs_read && avs_address == psc_pkg::REG_CTRL) begin
                r_nxt.rdata[psc_pkg::CTRL_AUTO_RETRY_BIT] = r.auto_retry;
                r_nxt.rdata[psc_pkg::CTRL_USE_INIT_DONE_BIT] = r.use_id;
                r_nxt.rdata[psc_pkg::CTRL_UCLK_EN_BIT] = r.uclk_en;
                r_nxt.rdata[psc_pkg::CTRL_CONFIG_CLOCK_INIT_BIT] = r.config_clock_init;
            end else if (avs_read && avs_address == psc_pkg::REG_STAT) begin
                r_nxt.rdata[psc_pkg::STAT_DONE_BIT] = r.done;
                r_nxt.rdata[psc_pkg::STAT_ERR_BIT] = r.err;
                r_nxt.rdata[psc_pkg::STAT_STATUS_PIN_BIT] = s_status;
                r_nxt.rdata[psc_pkg::STAT_CDONE_PIN_BIT] = s_cdone;
                r_nxt.rdata[psc_pkg::STAT_IDONE_PIN_BIT] = s_idone;
                r_nxt.rdata[psc_pkg::STAT_DATA_READY_BIT] = (r.st == psc_pkg::H_SEND) && (r.bits == 4'h0);
                r_nxt.rdata[psc_pkg::STAT_BUSY_BIT] = (r.st != psc_pkg::H_IDLE) && (r.st != psc_pkg::H_DONE)
                    && (r.st != psc_pkg::H_ERR);
            end else if (avs_write && avs_address == psc_pkg::REG_CTRL) begin
                r_nxt.auto_retry = avs_writedata[psc_pkg::CTRL_AUTO_RETRY_BIT];
                r_nxt.use_id = avs_writedata[psc_pkg::CTRL_USE_INIT_DONE_BIT];
                r_nxt.uclk_en = avs_writedata[psc_pkg::CTRL_UCLK_EN_BIT];
                r_nxt.config_clock_init = avs_writedata[psc_pkg::CTRL_CONFIG_CLOCK_INIT_BIT];
                if (avs_writedata[psc_pkg::CTRL_START_BIT]) begin
                    r_nxt.done = 1'b0;
                    r_nxt.err = 1'b0;
                    r_nxt.cnt = '0;
                    r_nxt.bits = '0;
                    r_nxt.cclk = 1'b0;
                    r_nxt.phase = '0;
                    if (avs_writedata[psc_pkg::CTRL_AUTO_RETRY_BIT] && r.st == psc_pkg::H_ERR && s_status) begin
                        r_nxt.st = psc_pkg::H_SEND;
                    end else begin
                        r_nxt.st = psc_pkg::H_PULSE;
                        r_nxt.req_n = 1'b0;
                    end
                end
            end else if (avs_write && avs_address == psc_pkg::REG_DATA && r.st == psc_pkg::H_SEND) begin
                r_nxt.shreg = avs_writedata[7:0];
                r_nxt.sdata = avs_writedata[0];
                r_nxt.bits = 4'h8;
                r_nxt.phase = '0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            r <= '{st: psc_pkg::H_IDLE, req_n: 1'b1, wait_r: 1'b1, default: '0};
        end else begin
            r <= r_nxt;
        end
    end

    assign link.config_request_n = r.req_n;
    assign link.config_clock = r.cclk;
    assign link.serial_data_in = r.sdata;
    assign link.user_init_clock = r.uclk;
    assign avs_readdata = r.rdata;
    assign avs_waitrequest = r.wait_r;
endmodule

// ---- dv/psc_checker.sv ----
// Checker for the configuration link between host and device
module psc_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic config_request_n,
    input wire logic status_n,
    input wire logic status_n_oe,
    input wire logic config_complete_oe,
    input wire logic init_complete_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Request held low long enough to pass the input synchroniser
    sequence s_req_low;
        !config_request_n [*8];
    endsequence
    AST_POR_HOLD: assert property ($fell(rst) |-> status_n_oe [*8])
        else $error("status released during power-on reset");
    AST_REQ_HOLD: assert property (s_req_low |-> status_n_oe)
        else $error("status released while request low");
    AST_REQ_PULL: assert property ($fell(config_request_n) |-> ##[1:6] (status_n_oe && config_complete_oe))
        else $error("request low did not pull status and complete");
    AST_RELEASE: assert property ($rose(config_request_n) |-> ##[1:8] !status_n_oe)
        else $error("status not released after request high");
    AST_INIT_HIGH: assert property (s_req_low |-> !init_complete_oe)
        else $error("init line pulled while request low");
    AST_INIT_LOW: assert property ($rose(init_complete_oe) |-> config_complete_oe && config_request_n)
        else $error("init line pulled outside configuration");
    AST_DONE_REL: assert property ($fell(config_complete_oe) |-> status_n && config_request_n)
        else $error("complete released without valid configuration");
    AST_DONE_HOLD: assert property (!config_complete_oe && config_request_n |=> !config_complete_oe)
        else $error("complete pulled low again without request");
endmodule

// ---- dv/testbench.sv ----
// Bench: host and device joined across the link, driven over Avalon-MM
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int INIT = 40;
    logic core_clk = 0, rst = 1, avs_read = 0, avs_write = 0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
    logic avs_waitrequest, cfg_byte_valid, cfg_error, user_mode, io_tristate, io_pullup_en;
    logic [7:0] cfg_byte, b, wsh_r = 8'h00;
    logic clk_d_r = 0, err_seen_r = 0;
    logic [7:0] exp_q[$], dev_q[$], wire_q[$];
    int bad_count = 0, n_checks = 0, cyc = 0, wn = 0, icnt = 0;
    psc_if psc_if_i();
    psc_device #(.INIT_CYCLES(INIT), .CFG_BYTES(4), .POR_CYCLES(20), .RESTART_CYCLES(50)) psc_device_i (.core_clk,
        .rst, .link(psc_if_i), .cfg_byte, .cfg_byte_valid, .cfg_error, .user_mode, .io_tristate, .io_pullup_en);
    psc_host #(.RECONF_CYCLES(20), .INIT_TIMEOUT(2000)) psc_host_i (.core_clk, .rst, .link(psc_if_i), .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
    psc_checker psc_checker_i (.core_clk, .rst, .config_request_n(psc_if_i.config_request_n),
        .status_n(psc_if_i.status_n), .status_n_oe(psc_if_i.status_n_oe),
        .config_complete_oe(psc_if_i.config_complete_oe), .init_complete_oe(psc_if_i.init_complete_oe));
    always #2 core_clk = ~core_clk;
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    // Wire monitor samples on the clock's rise, so it sees what the device latches
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        clk_d_r <= psc_if_i.config_clock;
        if (psc_if_i.config_clock && !clk_d_r && !psc_if_i.config_complete) begin
            wsh_r = {psc_if_i.serial_data_in, wsh_r[7:1]};
            wn = wn + 1;
            if (wn % 8 == 0) wire_q.push_back(wsh_r);
        end
        if (cfg_byte_valid === 1'b1) dev_q.push_back(cfg_byte);
        if (cfg_error === 1'b1) err_seen_r <= 1'b1;
        if (psc_if_i.config_complete && !psc_if_i.init_complete) icnt++;
        if (cyc == 40000) begin
            bad_count++;
            complete_run();
        end
    end
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Bounded only by the run's cycle ceiling
    task poll(input int bit_i);
        do bus(0, psc_pkg::REG_STAT, 32'h0000_0000); while (q[bit_i] !== 1'b1);
    endtask
    // Init phase length tolerates one tick of phase between clock and counter start
    function automatic logic in_range(input int n, input logic u);
        int p;
        p = u ? 2 * psc_pkg::UCLK_HALF : psc_pkg::OSC_DIV;
        return n >= (INIT - 1) * p && n <= (INIT + 1) * p;
    endfunction
    task run_cfg(input logic u, input logic good, input logic rt);
        exp_q.delete();
        dev_q.delete();
        wire_q.delete();
        wn = 0;
        icnt = 0;
        err_seen_r = 1'b0;
        bus(1, psc_pkg::REG_CTRL, 1 << psc_pkg::CTRL_START_BIT | 1 << psc_pkg::CTRL_USE_INIT_DONE_BIT
            | int'(u) << psc_pkg::CTRL_UCLK_EN_BIT | int'(rt) << psc_pkg::CTRL_AUTO_RETRY_BIT);
        chk(psc_if_i.config_request_n, rt);
        poll(psc_pkg::STAT_DATA_READY_BIT);
        chk(io_tristate, 1);
        chk(psc_if_i.init_complete, 1);
        for (int i = 0; i < (good ? 4 : 1); i++) begin
            b = i == 0 ? psc_pkg::SYNC_BYTE ^ (good ? 8'h00 : 8'h3c) : i == 1 ? 8'(1 << psc_pkg::OPT_INIT_DONE_BIT
                | 1 << psc_pkg::OPT_AUTO_RESTART_BIT | int'(u) << psc_pkg::OPT_USER_CLK_BIT) : 8'($urandom);
            exp_q.push_back(b);
            bus(1, psc_pkg::REG_DATA, {24'h00_0000, b});
        end
        if (good) begin
            chk(psc_if_i.init_complete, 0);
            poll(psc_pkg::STAT_DONE_BIT);
            chk(user_mode, 1);
            chk({io_pullup_en, io_tristate}, 0);
            chk(in_range(icnt, u), 1);
            chk(dev_q.size(), 4);
            foreach (exp_q[i]) chk(dev_q[i], exp_q[i]);
        end else begin
            poll(psc_pkg::STAT_ERR_BIT);
            chk({psc_if_i.status_n, err_seen_r}, 2'b01);
        end
        foreach (exp_q[i]) chk(wire_q[i], exp_q[i]);
    endtask
    initial begin
        b = 8'($urandom(35));
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        bus(0, 4'hc, 32'h0000_0000);
        chk(q, 0);
        // Bad sync byte, then restart by request pulse and configure into user mode
        run_cfg(0, 0, 0);
        run_cfg(0, 1, 0);
        // From user mode a bad stream now restarts by itself, and the host retries without a pulse
        run_cfg(1, 0, 0);
        poll(psc_pkg::STAT_STATUS_PIN_BIT);
        run_cfg(1, 1, 1);
        complete_run();
    end
endmodule
